// file: rtl/pmw_ctrl.sv
// Power mode, wake-up, interrupt and reset stretch controller
// Summary of operation
// - Three modes Normal, Stop, Sleep from control bits
// - Missed power stage bit forces Sleep mode
// - Test strap disables start-up supervision timeout
// - Stop wakes MCU by masked interrupt pulse
// - Sleep turns regulator off, holds reset low
// - Sleep wake unmasked, resets, records wake source
// - Seven maskable sources pulse the interrupt pin
// - Reset clears every mask register bit
// - Low supply sets flag, off in Stop/Sleep
// - High supply sets flag, off in Stop/Sleep
// - High temperature sets flag, off in Stop/Sleep
// - Long dominant then rising edge sets bus flag
// - Hall edge sets flag in Normal mode when hall mode allows
// - Wake input edge sets flag in Normal and Stop modes
// - Write one clears flag, zero keeps it
// - Clear ignored while supply/temperature condition persists
// - Power stage flag read-only, follows fail flags
// - Overtemp reset disable bit suppresses thermal reset
// - Internal resets stretch reset pin 1.25 ms
// - Sleep bus wake sets bus wake reset flag
`timescale 1ns/1ps
module pmw_ctrl #(
  parameter int SUPERVISE_CYC = 3200000,
  parameter int RST_STRETCH_CYC = 50000,
  parameter int WAKE_DOM_CYC = 2000
) (
  input wire logic clk,
  input wire logic reset,
  input wire pmw_pkg::pmw_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic bus_rx,
  input wire logic wake_input_pin,
  input wire logic hall_input_pin,
  input wire logic hall_irq_allowed,
  input wire logic factory_test_strap,
  input wire pmw_pkg::pmw_analog_t analog_in,
  input wire logic mcu_reset_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  output logic regulator_on,
  output logic [2:0] mode_state
);
  import pmw_pkg::*;

  // Elaboration checks on counts
  if (SUPERVISE_CYC < 1 || RST_STRETCH_CYC < 1 || WAKE_DOM_CYC < 1) begin : g_bad_counts
    $error("pmw_ctrl: counts must be at least one cycle");
  end

  // Synchronised pins and analog levels
  // Bus level enters inverted, so the cleared chain reads recessive
  // and no false rising edge follows reset
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync_q; // Chain output, one bit per pin
  logic bus_dom_s; // Bus dominant level
  logic wake_s; // Wake input level
  logic hall_s; // Hall input level
  logic hall_ok_s; // Hall interrupt allowed by configuration
  logic strap_s; // Test strap level
  logic ext_rst_s; // Reset pin read back low
  pmw_analog_t ana_s; // Analog condition levels
  pmw_sync #(.WIDTH(NSYNC)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({~bus_rx, wake_input_pin, hall_input_pin, hall_irq_allowed, factory_test_strap,
               ~mcu_reset_in, analog_in}),
    .sync_out(sync_q)
  );
  assign {bus_dom_s, wake_s, hall_s, hall_ok_s, strap_s, ext_rst_s, ana_s} = sync_q;
  wire bus_rx_s = !bus_dom_s; // Bus recessive level

  // Registers
  pmw_mode_t mode_r, mode_nxt;
  logic [7:0] mask_r; // Interrupt enable mask
  logic [7:0] flags_r; // Interrupt flags (bit 7 derived)
  logic [7:0] sysctl_r; // Power stage, stop, sleep bits
  logic [1:0] wakef_r; // Sleep wake source flags
  logic wake_prev_r; // Wake level one cycle back
  logic hall_prev_r; // Hall level one cycle back
  logic bus_prev_r; // Bus level one cycle back
  logic [1:0] oe_hist_r; // Reset pin enable, two cycles of history
  logic [$clog2(WAKE_DOM_CYC+1)-1:0] dom_cnt_r;
  logic dom_long_r; // Dominant lasted long enough
  logic [$clog2(SUPERVISE_CYC+1)-1:0] sup_cnt_r;
  logic [$clog2(RST_STRETCH_CYC+1)-1:0] rst_cnt_r;
  logic [3:0] irq_cnt_r;
  logic [7:0] pend_prev_r;

  // Access decode
  // Requests are single-cycle strobes; a write lands on the edge that sees it
  wire wr_mask = reg_req.wr && reg_req.addr == PMW_ADDR_MASK;
  wire wr_flags = reg_req.wr && reg_req.addr == PMW_ADDR_FLAGS;
  wire wr_sysctl = reg_req.wr && reg_req.addr == PMW_ADDR_SYSCTL;
  wire wr_rststat = reg_req.wr && reg_req.addr == PMW_ADDR_RSTSTAT;

  // Mode decode
  // Decoded once from the one-hot state
  wire run = mode_r == PMW_NORMAL;
  wire in_stop = mode_r == PMW_STOP;
  wire in_sleep = mode_r == PMW_SLEEP;

  // Bus wake: long dominant followed by rising edge
  // Timer saturates, so any longer dominant level still qualifies
  wire bus_rise = bus_rx_s && !bus_prev_r;
  wire bus_wake = bus_rise && dom_long_r;
  wire wake_edge = wake_s != wake_prev_r;
  wire hall_edge = hall_s != hall_prev_r;

  // Hardware set terms per flag
  wire [7:0] set_v;
  assign set_v[PMW_BIT_WAKEIN] = wake_edge && !in_sleep;
  assign set_v[PMW_BIT_HALL] = run && hall_edge && hall_ok_s;
  assign set_v[PMW_BIT_BUS] = bus_wake && !in_sleep;
  assign set_v[PMW_BIT_OVERTEMP_RESET_DISABLE] = 1'b0;
  assign set_v[PMW_BIT_HTEMP] = run && ana_s.high_temp;
  assign set_v[PMW_BIT_LOWSUP] = run && ana_s.low_supply;
  assign set_v[PMW_BIT_HIGHSUP] = run && ana_s.high_supply;
  assign set_v[PMW_BIT_PSF] = 1'b0;

  // Conditions that block a clear while present
  wire [7:0] hold_v;
  assign hold_v = {1'b0, ana_s.high_supply, ana_s.low_supply, ana_s.high_temp, 4'h0};

  // Clear mask: write one clears, zero keeps, set wins
  // Set terms are ORed after the clear, so an event beats a clear in one cycle
  wire [7:0] clr_v = (wr_flags ? reg_req.wdata : 8'h00) & ~hold_v;
  wire [6:0] flags_nxt = (flags_r[6:0] & ~clr_v[6:0]) | set_v[6:0];

  // Power stage fail is read-only, mirrors outside fail flags
  wire psf = run && ana_s.power_fail;
  wire [7:0] flags_view = {psf, flags_r[6:4], 1'b0, flags_r[2:0]}; // Flag register as read

  // Pending interrupts excluding the reset disable bit
  // The reset disable bit shares the mask register but enables no interrupt
  wire [7:0] irq_mask = mask_r & ~(8'h01 << PMW_BIT_OVERTEMP_RESET_DISABLE);
  wire [7:0] pending = flags_view & irq_mask;
  wire new_pend = |(pending & ~pend_prev_r);

  // Internal reset causes
  wire ot_rst = ana_s.overtemp_reset && !mask_r[PMW_BIT_OVERTEMP_RESET_DISABLE];
  wire int_rst = ot_rst || ana_s.undervoltage_reset || ana_s.watchdog_reset;
  // Reset pin readback counts as external only while this block has released it;
  // the readback lags by the two synchroniser stages, so it is blanked until the
  // enable has stood released for two cycles, else the block holds itself in reset
  wire ext_rst = ext_rst_s && reset_pin_oe_n && (&oe_hist_r);
  // Supervision only watches Normal mode; the test strap stops it
  wire sup_expired = run && !strap_s && !sysctl_r[PMW_BIT_POWER_STAGE_ON_BIT]
                     && sup_cnt_r == ($bits(sup_cnt_r))'(SUPERVISE_CYC);
  wire sleep_wake = in_sleep && (bus_wake || wake_edge);
  wire spi_reset = int_rst || sleep_wake; // Clears registers except wake flags

  // Mode transitions
  // Sleep wins over Stop when both request bits come in one write
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMW_NORMAL: begin
        if (sup_expired || (wr_sysctl && reg_req.wdata[PMW_BIT_SLEEP])) begin
          mode_nxt = PMW_SLEEP;
        end else if (wr_sysctl && reg_req.wdata[PMW_BIT_STOP]) begin
          mode_nxt = PMW_STOP;
        end
      end
      PMW_STOP: begin
        if (wr_sysctl && reg_req.wdata[PMW_BIT_SLEEP]) begin
          mode_nxt = PMW_SLEEP;
        end else if (|pending || (wr_sysctl && !reg_req.wdata[PMW_BIT_STOP])) begin
          mode_nxt = PMW_NORMAL;
        end
      end
      PMW_SLEEP: begin
        if (sleep_wake) begin
          mode_nxt = PMW_NORMAL;
        end
      end
      default: mode_nxt = PMW_NORMAL;
    endcase
  end

  // Mode register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= PMW_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Mask and system control registers
  // Every internal cause clears the register set except the wake flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r <= PMW_MASK_RST;
      sysctl_r <= PMW_SYSCTL_RST;
    end else if (spi_reset) begin
      mask_r <= PMW_MASK_RST;
      sysctl_r <= PMW_SYSCTL_RST;
    end else begin
      if (wr_mask) begin
        mask_r <= reg_req.wdata;
      end
      if (wr_sysctl) begin
        sysctl_r <= reg_req.wdata;
      end else if (mode_r != mode_nxt) begin
        sysctl_r[PMW_BIT_STOP] <= 1'b0; // Mode bits drop once acted on
        sysctl_r[PMW_BIT_SLEEP] <= 1'b0;
      end
    end
  end

  // Interrupt flags
  // Bit 3 has no flag behind it and bit 7 is derived, so both store zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_r <= PMW_FLAGS_RST;
    end else if (spi_reset) begin
      flags_r <= PMW_FLAGS_RST;
    end else begin
      flags_r <= {1'b0, flags_nxt[6:4], 1'b0, flags_nxt[2:0]};
    end
  end

  // Sleep wake source flags, survive wake-up reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wakef_r <= 2'b00;
    end else begin
      wakef_r <= (wakef_r & ~(wr_rststat ? reg_req.wdata[1:0] : 2'b00))
                 | {sleep_wake && wake_edge, sleep_wake && bus_wake};
    end
  end

  // Edge history and dominant timer
  // Reset values match the idle levels of the synchronised pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_prev_r <= 1'b0;
      hall_prev_r <= 1'b0;
      bus_prev_r <= 1'b1;
      dom_cnt_r <= '0;
      dom_long_r <= 1'b0;
    end else begin
      wake_prev_r <= wake_s;
      hall_prev_r <= hall_s;
      bus_prev_r <= bus_rx_s;
      if (bus_rx_s) begin
        dom_cnt_r <= '0; // Recessive restarts the timer
        dom_long_r <= 1'b0;
      end else if (dom_cnt_r == ($bits(dom_cnt_r))'(WAKE_DOM_CYC)) begin
        dom_long_r <= 1'b1;
      end else begin
        dom_cnt_r <= dom_cnt_r + 1'b1;
      end
    end
  end

  // Start-up supervision counter, restarts on every reset
  // Counting waits for reset pin release, so the window is time the processor ran
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sup_cnt_r <= '0;
    end else if (spi_reset || rst_cnt_r != '0 || !run) begin
      sup_cnt_r <= '0;
    end else if (strap_s || sysctl_r[PMW_BIT_POWER_STAGE_ON_BIT]) begin
      sup_cnt_r <= '0;
    end else if (sup_cnt_r != ($bits(sup_cnt_r))'(SUPERVISE_CYC)) begin
      sup_cnt_r <= sup_cnt_r + 1'b1;
    end
  end

  // Reset pin enable history for readback blanking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oe_hist_r <= 2'b00; // Pin is driven low during reset
    end else begin
      oe_hist_r <= {oe_hist_r[0], reset_pin_oe_n};
    end
  end

  // Reset stretch: reload while cause present, count after
  // Sleep keeps the count loaded, so the wake-up reset is stretched too
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_cnt_r <= ($bits(rst_cnt_r))'(RST_STRETCH_CYC);
    end else if (int_rst || in_sleep || ext_rst) begin
      rst_cnt_r <= ($bits(rst_cnt_r))'(RST_STRETCH_CYC);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - 1'b1;
    end
  end

  // Interrupt pulse generator
  // A source arriving during a running pulse restarts it; simultaneous sources share one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_cnt_r <= 4'h0;
      pend_prev_r <= 8'h00;
    end else begin
      pend_prev_r <= pending;
      if (new_pend && !in_sleep) begin
        irq_cnt_r <= PMW_IRQ_PULSE_CYC;
      end else if (irq_cnt_r != 4'h0) begin
        irq_cnt_r <= irq_cnt_r - 1'b1;
      end
    end
  end

  // Pin and status outputs from flops
  // Open-drain pins: data stays low, the enable carries the level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_pin_oe_n <= 1'b1;
      regulator_on <= 1'b1;
      mode_state <= PMW_NORMAL;
      reg_rdata <= 8'h00;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !(in_sleep || rst_cnt_r != '0 || int_rst);
      irq_pin_out <= 1'b0;
      irq_pin_oe_n <= !(irq_cnt_r != 4'h0);
      regulator_on <= !in_sleep;
      mode_state <= mode_r;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          PMW_ADDR_MASK: reg_rdata <= mask_r;
          PMW_ADDR_FLAGS: reg_rdata <= flags_view;
          PMW_ADDR_SYSCTL: reg_rdata <= sysctl_r;
          PMW_ADDR_RSTSTAT: reg_rdata <= {6'h00, wakef_r};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // pmw_ctrl

// file: rtl/pmw_pkg.sv
// Package: constants, types and register layout of the power mode and wake-up controller
package pmw_pkg;
  // Register addresses
  localparam logic [7:0] PMW_ADDR_MASK = 8'h09;
  localparam logic [7:0] PMW_ADDR_FLAGS = 8'h0a;
  localparam logic [7:0] PMW_ADDR_SYSCTL = 8'h06;
  localparam logic [7:0] PMW_ADDR_RSTSTAT = 8'h0d;
  // Bit positions shared by flag and mask registers
  localparam int PMW_BIT_WAKEIN = 0;
  localparam int PMW_BIT_HALL = 1;
  localparam int PMW_BIT_BUS = 2;
  localparam int PMW_BIT_OVERTEMP_RESET_DISABLE = 3;
  localparam int PMW_BIT_HTEMP = 4;
  localparam int PMW_BIT_LOWSUP = 5;
  localparam int PMW_BIT_HIGHSUP = 6;
  localparam int PMW_BIT_PSF = 7;
  // System control bit positions
  localparam int PMW_BIT_POWER_STAGE_ON_BIT = 0;
  localparam int PMW_BIT_STOP = 1;
  localparam int PMW_BIT_SLEEP = 2;
  // Reset status wake flag positions
  localparam int PMW_BIT_BUSWF = 0;
  localparam int PMW_BIT_PINWF = 1;
  // Reset values
  localparam logic [7:0] PMW_MASK_RST = 8'h00;
  localparam logic [7:0] PMW_FLAGS_RST = 8'h00;
  localparam logic [7:0] PMW_SYSCTL_RST = 8'h00;
  // Timing
  localparam longint PMW_CLK_HZ = 40000000;
  localparam longint PMW_SUPERVISE_US = 80000;
  localparam longint PMW_RST_STRETCH_NS = 1250000;
  localparam longint PMW_WAKE_DOM_NS = 50000;
  localparam longint PMW_SUPERVISE_CYC = PMW_SUPERVISE_US * PMW_CLK_HZ / 1000000;
  localparam longint PMW_RST_STRETCH_CYC = PMW_RST_STRETCH_NS * PMW_CLK_HZ / 1000000000;
  localparam longint PMW_WAKE_DOM_CYC = (PMW_WAKE_DOM_NS * PMW_CLK_HZ + 999999999) / 1000000000;
  localparam logic [3:0] PMW_IRQ_PULSE_CYC = 4'h8;
  // Operating modes, one-hot
  typedef enum logic [2:0] {
    PMW_NORMAL = 3'b001,
    PMW_STOP = 3'b010,
    PMW_SLEEP = 3'b100
  } pmw_mode_t;
  // Register access strobe group
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmw_reg_req_t;
  // Analog condition inputs
  typedef struct packed {
    logic low_supply;
    logic high_supply;
    logic high_temp;
    logic power_fail;
    logic overtemp_reset;
    logic undervoltage_reset;
    logic watchdog_reset;
  } pmw_analog_t;
endpackage

// file: rtl/pmw_sync.sv
// Two-flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module pmw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage, read only by second stage
  logic [WIDTH-1:0] meta_r;
  // Two stages in series
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // pmw_sync

// file: sim/pmw_ctrl_props.sv
// Port checker for the power mode controller
`timescale 1ns/1ps
module pmw_ctrl_props #(
  parameter int RST_STRETCH_CYC = 50000
) (
  input wire logic clk,
  input wire logic reset,
  input wire pmw_pkg::pmw_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire pmw_pkg::pmw_analog_t analog_in,
  input wire logic reset_pin_oe_n,
  input wire logic irq_pin_oe_n,
  input wire logic regulator_on,
  input wire logic [2:0] mode_state
);
  import pmw_pkg::*;
  int low_cnt;
  // Cycles the reset pin has been pulled low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) low_cnt <= 0;
    else if (reset_pin_oe_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_one_mode;
    $onehot(mode_state);
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode not one-hot");
  property p_sleep_off;
    mode_state == PMW_SLEEP ##1 mode_state == PMW_SLEEP |-> !regulator_on && !reset_pin_oe_n;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep leaves power on");
  property p_wake_normal;
    $past(mode_state) == PMW_SLEEP && mode_state != PMW_SLEEP |-> mode_state == PMW_NORMAL && !reset_pin_oe_n;
  endproperty
  a_wake_normal: assert property (p_wake_normal) else $error("bad sleep exit");
  property p_irq_len;
    $fell(irq_pin_oe_n) |=> (!irq_pin_oe_n)[*7] ##1 irq_pin_oe_n;
  endproperty
  a_irq_len: assert property (p_irq_len) else $error("irq pulse length");
  property p_stretch;
    $rose(reset_pin_oe_n) |-> low_cnt >= RST_STRETCH_CYC;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset pulse short");
  property p_mask_rw;
    (reg_req.wr && reg_req.addr == PMW_ADDR_MASK) ##2 (reg_req.rd && reg_req.addr == PMW_ADDR_MASK)
      |=> reg_rdata == $past(reg_req.wdata, 3);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask readback");
  property p_low_flag;
    (analog_in.low_supply && mode_state == PMW_NORMAL)[*5] ##1 (reg_req.rd && reg_req.addr == PMW_ADDR_FLAGS)
      |=> reg_rdata[PMW_BIT_LOWSUP];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low supply flag");
  property p_psf;
    (analog_in.power_fail && mode_state == PMW_NORMAL)[*5] ##1 (reg_req.rd && reg_req.addr == PMW_ADDR_FLAGS)
      |=> reg_rdata[PMW_BIT_PSF];
  endproperty
  a_psf: assert property (p_psf) else $error("power fail flag");
endmodule // pmw_ctrl_props

// file: sim/pmw_mcu_model.sv
// Processor model: register strobes and reset wire
`timescale 1ns/1ps
module pmw_mcu_model (
  input wire logic clk,
  output pmw_pkg::pmw_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  output logic mcu_reset_in
);
  import pmw_pkg::*;
  // Pulled-up open-drain reset wire
  assign mcu_reset_in = reset_pin_oe_n | reset_pin_out;
  // Idle strobes
  initial reg_req = '0;
  // One byte, strobe held over one taken edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req = '0;
    q = reg_rdata;
  endtask
  // Proves the processor runs
  task automatic power_stage_on_bit;
    logic [7:0] q;
    acc(1'b1, PMW_ADDR_SYSCTL, 8'h01, q);
  endtask
endmodule // pmw_mcu_model

// file: sim/pmw_ctrl_bench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module pmw_ctrl_bench;
  import pmw_pkg::*;
  logic clk, reset, bus_rx, wk, hall, strap, rst_out, rst_oe_n, irq_oe_n, reg_on, mrst, hok, irq_out;
  logic [7:0] rdata, q;
  logic [2:0] mode;
  pmw_analog_t an;
  pmw_reg_req_t rq;
  int bad_count = 0;
  int n_compared = 0;
  int irqs = 0;
  int fb[3] = '{5, 6, 4};
  // 40 MHz clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Interrupt pulse count
  always @(negedge irq_oe_n) irqs++;
  pmw_ctrl #(.SUPERVISE_CYC(200), .RST_STRETCH_CYC(20), .WAKE_DOM_CYC(10)) dut (.clk(clk), .reset(reset),
    .reg_req(rq), .reg_rdata(rdata), .bus_rx(bus_rx), .wake_input_pin(wk), .hall_input_pin(hall),
    .hall_irq_allowed(hok), .factory_test_strap(strap), .analog_in(an), .mcu_reset_in(mrst),
    .reset_pin_out(rst_out), .reset_pin_oe_n(rst_oe_n), .irq_pin_out(irq_out), .irq_pin_oe_n(irq_oe_n),
    .regulator_on(reg_on), .mode_state(mode));
  pmw_mcu_model mcu (.clk(clk), .reg_req(rq), .reg_rdata(rdata), .reset_pin_out(rst_out),
    .reset_pin_oe_n(rst_oe_n), .mcu_reset_in(mrst));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmpm(input logic [2:0] e);
    cmp({5'h0, mode}, {5'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    mcu.acc(1'b0, a, 8'h00, q);
    cmp(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mcu.acc(1'b1, a, d, q);
  endtask
  // Bounded wait for reset pin release
  task automatic rel;
    for (int i = 0; i < 100 && rst_oe_n !== 1'b1; i++) cyc(1);
    cmp({7'h0, rst_oe_n}, 8'h01);
  endtask
  task automatic t_start;
    rel();
    cmp({6'h0, irq_out, rst_out}, 8'h00);
    rd(PMW_ADDR_MASK, 8'h00);
    rd(PMW_ADDR_FLAGS, 8'h00);
    cmpm(PMW_NORMAL);
    mcu.power_stage_on_bit();
  endtask
  // Pin edges, masked then enabled
  task automatic t_pins;
    int n;
    n = irqs;
    wk = 1;
    cyc(6);
    rd(PMW_ADDR_FLAGS, 8'h01);
    wr(PMW_ADDR_MASK, 8'hf7);
    rd(PMW_ADDR_MASK, 8'hf7);
    cmp(8'(irqs - n), 8'h01);
    hok = 0;
    hall = 1;
    cyc(12);
    rd(PMW_ADDR_FLAGS, 8'h01);
    hok = 1;
    hall = 0;
    cyc(12);
    rd(PMW_ADDR_FLAGS, 8'h03);
    cmp(8'(irqs - n), 8'h02);
    wr(PMW_ADDR_FLAGS, 8'h00);
    rd(PMW_ADDR_FLAGS, 8'h03);
    wr(PMW_ADDR_FLAGS, 8'h03);
    rd(PMW_ADDR_FLAGS, 8'h00);
  endtask
  // Supply, temperature and power stage conditions
  task automatic t_analog;
    for (int j = 0; j < 3; j++) begin
      an = 7'h40 >> j;
      cyc(6);
      wr(PMW_ADDR_FLAGS, 8'h70);
      rd(PMW_ADDR_FLAGS, 8'h01 << fb[j]);
      an = '0;
      cyc(4);
      wr(PMW_ADDR_FLAGS, 8'h70);
      rd(PMW_ADDR_FLAGS, 8'h00);
    end
    an.power_fail = 1;
    cyc(6);
    wr(PMW_ADDR_FLAGS, 8'h80);
    rd(PMW_ADDR_FLAGS, 8'h80);
    an = '0;
    cyc(6);
    rd(PMW_ADDR_FLAGS, 8'h00);
  endtask
  // Stop, short then long dominant bus
  task automatic t_stop;
    int n;
    wr(PMW_ADDR_SYSCTL, 8'h03);
    cyc(3);
    cmpm(PMW_STOP);
    an.low_supply = 1;
    bus_rx = 0;
    cyc(5);
    bus_rx = 1;
    cyc(8);
    an = '0;
    cmpm(PMW_STOP);
    n = irqs;
    bus_rx = 0;
    cyc(15);
    bus_rx = 1;
    cyc(12);
    cmp(8'(irqs - n), 8'h01);
    cmpm(PMW_NORMAL);
    rd(PMW_ADDR_FLAGS, 8'h04);
    wr(PMW_ADDR_FLAGS, 8'h04);
    mcu.power_stage_on_bit();
  endtask
  // Sleep, woken by bus then by pin
  task automatic t_sleep;
    for (int s = 0; s < 2; s++) begin
      wr(PMW_ADDR_SYSCTL, 8'h05);
      cyc(3);
      cmpm(PMW_SLEEP);
      cmp({6'h0, reg_on, rst_oe_n}, 8'h00);
      if (s == 0) begin
        bus_rx = 0;
        cyc(15);
        bus_rx = 1;
      end else wk = !wk;
      cyc(6);
      cmpm(PMW_NORMAL);
      rel();
      rd(PMW_ADDR_MASK, 8'h00);
      rd(PMW_ADDR_RSTSTAT, 8'h01 << s);
      wr(PMW_ADDR_RSTSTAT, 8'h03);
      mcu.power_stage_on_bit();
    end
  endtask
  // Internal resets, then start-up supervision
  task automatic t_intreset;
    wr(PMW_ADDR_MASK, 8'h08);
    an.overtemp_reset = 1;
    cyc(4);
    cmp({7'h0, rst_oe_n}, 8'h01);
    an = 7'h02;
    cyc(4);
    an = '0;
    cyc(19);
    cmp({7'h0, rst_oe_n}, 8'h00);
    rel();
    rd(PMW_ADDR_MASK, 8'h00);
    // Thermal reset without disable, then watchdog reset
    for (int k = 0; k < 2; k++) begin
      wr(PMW_ADDR_MASK, 8'h01);
      an = (k == 0) ? 7'h04 : 7'h01;
      cyc(4);
      an = '0;
      cyc(2);
      cmp({7'h0, rst_oe_n}, 8'h00);
      rel();
      rd(PMW_ADDR_MASK, 8'h00);
    end
    strap = 1;
    cyc(250);
    cmpm(PMW_NORMAL);
    strap = 0;
    for (int i = 0; i < 260 && mode !== PMW_SLEEP; i++) cyc(1);
    cmpm(PMW_SLEEP);
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1;
    bus_rx = 1;
    wk = 0;
    hall = 0;
    hok = 1;
    strap = 0;
    an = '0;
    cyc(6);
    reset = 0;
    t_start();
    t_pins();
    t_analog();
    t_stop();
    t_sleep();
    t_intreset();
    final_report();
  end
  // Watchdog
  initial begin
    #500000;
    bad_count++;
    final_report();
  end
endmodule // pmw_ctrl_bench
bind pmw_ctrl pmw_ctrl_props #(.RST_STRETCH_CYC(RST_STRETCH_CYC)) u_props (.clk(clk), .reset(reset),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .analog_in(analog_in), .reset_pin_oe_n(reset_pin_oe_n),
  .irq_pin_oe_n(irq_pin_oe_n), .regulator_on(regulator_on), .mode_state(mode_state));
